// File: pra_packet_ram_arbiter.sv
// Purpose: Packet RAM arbiter with host data path and MAC DMA engine.
// Assumes: clk is the free-running 50 MHz clock from the crystal doubler.
// Notes:   Host bus clock logic is a second domain joined by toggles.
// Behaviour
// - Core and DMA run on the 50 MHz clock made from the 25 MHz crystal.
// - One arbiter serialises host data-register and MAC DMA memory requests.
// - RAM cycles last long enough for 25 ns 32k x 8 SRAMs, four wide.
// - Back-to-back host doublewords complete every 80 ns with MAC interleaved.
// - Only byte write strobes of the bytes being written go low.
// - Reads fetch whole words; lanes are steered by the access address.
// - Separate read and write paths at the data register take any width.
// - Host sees not-ready until its cycle can be satisfied.
// - Write buffering absorbs arbitration delay; host write cycles stretch only while the buffer is full.
// - DMA moves 32-bit words between MAC FIFOs and packet memory.
// - Separate TX and RX counters; simultaneous needs alternate TX and RX.
// - MAC FIFO memory-side ports hold full 32-bit words.
// - Host address held in transparent latches closed by rising address strobe.
// - Async ready drops once the synchronised strobe is seen, rises timed by the core clock.
// - Sync mode cycles framed by cycle start; sync ready driven on bus clock.
// - Data port select bypasses decoding for sequential external DMA access.
`timescale 1ns/1ps
module pra_packet_ram_arbiter #(
  parameter int WBUF_DEPTH = pra_pkg::WBUF_DEPTH_DEF
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          local_bus_clock,
  input  wire logic                          local_bus_mode_n,
  input  wire logic                          cycle_start_n,
  output logic                               sync_ready_n,
  input  wire logic                          address_strobe_n,
  input  wire logic [pra_pkg::HADDR_W-1:0]   host_address,
  input  wire logic [pra_pkg::BE_W-1:0]      host_byte_enable_n,
  input  wire logic                          host_write_not_read,
  input  wire logic                          host_read_strobe_n,
  input  wire logic                          host_write_strobe_n,
  input  wire logic                          data_port_select_n,
  input  wire logic                          data_reg_select,
  input  wire logic                          host_bus16,
  input  wire logic [pra_pkg::DATA_W-1:0]    host_data_in,
  output logic [pra_pkg::DATA_W-1:0]         host_data_out,
  output logic                               host_data_oe,
  output logic                               async_ready,
  input  wire logic                          ptr_load,
  input  wire logic [pra_pkg::RAM_AW-1:0]    ptr_value,
  input  wire logic                          tx_addr_load,
  input  wire logic [pra_pkg::RAM_AW-1:0]    tx_addr_value,
  input  wire logic                          tx_fetch_req,
  output logic                               tx_word_valid,
  output logic [pra_pkg::DATA_W-1:0]         tx_word,
  input  wire logic                          tx_word_ready,
  input  wire logic                          rx_addr_load,
  input  wire logic [pra_pkg::RAM_AW-1:0]    rx_addr_value,
  input  wire logic                          rx_word_valid,
  input  wire logic [pra_pkg::DATA_W-1:0]    rx_word,
  output logic                               rx_word_taken,
  output logic [pra_pkg::RAM_AW-1:0]         ram_address_lines,
  input  wire logic [pra_pkg::DATA_W-1:0]    ram_data_in,
  output logic [pra_pkg::DATA_W-1:0]         ram_data_lines,
  output logic                               ram_data_oe,
  output logic                               ram_output_enable_n,
  output logic [pra_pkg::BE_W-1:0]           ram_byte_write_strobes_n
);
  import pra_pkg::*;

  localparam int WP_W = (WBUF_DEPTH > 1) ? $clog2(WBUF_DEPTH) : 1;
  localparam int WC_W = $clog2(WBUF_DEPTH + 1);

  // Swapping halves is its own inverse, so one function serves both ways
  function automatic logic [DATA_W-1:0] lane_steer(
    input logic [DATA_W-1:0] d,
    input logic              a1,
    input logic              bus16
  );
    lane_steer = (bus16 && a1) ? {d[15:0], d[31:16]} : d;
  endfunction

  logic [HADDR_W-1:0] addr_latch;
  always_latch begin
    if (!address_strobe_n) begin
      addr_latch <= host_address;
    end
  end

  logic        cs_s1, cs_s2, cs_s3;
  logic        ack_s1, ack_s2, ack_s3;
  logic        ack_tgl_reg;
  logic        lreq_tgl_reg;
  pra_hreq_s   lreq_reg;
  pra_lbus_e   lstate_reg;

  always_ff @(posedge local_bus_clock or posedge reset) begin
    if (reset) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      cs_s1  <= cycle_start_n;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      ack_s1 <= ack_tgl_reg;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // Request fields stay stable while the toggle crosses; the core reads
  // them only after it has seen the toggle twice registered.
  always_ff @(posedge local_bus_clock or posedge reset) begin
    if (reset) begin
      lstate_reg   <= L_IDLE;
      lreq_tgl_reg <= 1'b0;
      lreq_reg     <= '0;
      sync_ready_n <= 1'b1;
    end else begin
      sync_ready_n <= 1'b1;
      case (lstate_reg)
        L_IDLE: begin
          if (!cs_s2 && cs_s3) begin
            lreq_reg.write <= host_write_not_read;
            lreq_reg.hit   <= !data_port_select_n || data_reg_select;
            lreq_reg.a1    <= addr_latch[0];
            lreq_reg.be_n  <= host_byte_enable_n;
            lreq_reg.data  <= host_data_in;
            lreq_tgl_reg   <= !lreq_tgl_reg;
            lstate_reg     <= L_WAIT;
          end
        end
        L_WAIT: begin
          if (ack_s2 != ack_s3) begin
            sync_ready_n <= 1'b0;
            lstate_reg   <= L_IDLE;
          end
        end
        default: lstate_reg <= L_IDLE;
      endcase
    end
  end

  logic      mode_s1, mode_s2;
  logic      rt_s1, rt_s2, rt_s3;
  logic      rd_s1, rd_s2, rd_s3;
  logic      wr_s1, wr_s2, wr_s3;
  pra_hreq_s hreq_reg;
  pra_host_e hstate_reg;
  logic      hsync_reg;
  logic      rd_pend_reg;
  logic [RAM_AW-1:0] ptr_reg;
  logic [DATA_W-1:0] rdata_next;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_s1 <= 1'b1;
      mode_s2 <= 1'b1;
      rt_s1   <= 1'b0;
      rt_s2   <= 1'b0;
      rt_s3   <= 1'b0;
      rd_s1   <= 1'b1;
      rd_s2   <= 1'b1;
      rd_s3   <= 1'b1;
      wr_s1   <= 1'b1;
      wr_s2   <= 1'b1;
      wr_s3   <= 1'b1;
    end else begin
      mode_s1 <= local_bus_mode_n;
      mode_s2 <= mode_s1;
      rt_s1   <= lreq_tgl_reg;
      rt_s2   <= rt_s1;
      rt_s3   <= rt_s2;
      rd_s1   <= host_read_strobe_n;
      rd_s2   <= rd_s1;
      rd_s3   <= rd_s2;
      wr_s1   <= host_write_strobe_n;
      wr_s2   <= wr_s1;
      wr_s3   <= wr_s2;
    end
  end

  logic sync_start, async_rd_start, async_wr_start, async_start;
  assign sync_start     = !mode_s2 && (rt_s2 != rt_s3);
  assign async_rd_start = mode_s2 && !rd_s2 && rd_s3;
  assign async_wr_start = mode_s2 && !wr_s2 && wr_s3;
  assign async_start    = async_rd_start || async_wr_start;

  // Write buffer signals, shared with the arbiter
  pra_wentry_s wb_mem [WBUF_DEPTH];
  logic [WP_W-1:0] wb_wptr_reg, wb_rptr_reg;
  logic [WC_W-1:0] wb_count_reg;
  logic wb_full, wb_empty, wb_push, wb_pop;
  logic hrd_done;
  assign wb_full  = (wb_count_reg == WC_W'(WBUF_DEPTH));
  assign wb_empty = (wb_count_reg == '0);
  // Ready to fill is !wb_full; a full buffer stalls the host cycle
  assign wb_push  = (hstate_reg == H_EXEC) && hreq_reg.write &&
                    hreq_reg.hit && !wb_full;
  logic host_hit_done;
  assign host_hit_done = (hstate_reg == H_EXEC) &&
                         (!hreq_reg.hit || (hreq_reg.write && !wb_full));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hstate_reg    <= H_IDLE;
      hreq_reg      <= '0;
      hsync_reg     <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      async_ready   <= 1'b1;
      host_data_oe  <= 1'b0;
      host_data_out <= WORD_RESET;
    end else begin
      case (hstate_reg)
        H_IDLE: begin
          if (sync_start) begin
            hreq_reg     <= lreq_reg;
            hsync_reg    <= 1'b1;
            host_data_oe <= 1'b0;
            hstate_reg   <= H_EXEC;
          end else if (async_start) begin
            hreq_reg.write <= async_wr_start;
            hreq_reg.hit   <= !data_port_select_n || data_reg_select;
            hreq_reg.a1    <= addr_latch[0];
            hreq_reg.be_n  <= host_byte_enable_n;
            hreq_reg.data  <= host_data_in;
            hsync_reg      <= 1'b0;
            async_ready    <= 1'b0;
            hstate_reg     <= H_EXEC;
          end
        end
        H_EXEC: begin
          if (host_hit_done) begin
            hstate_reg <= hsync_reg ? H_IDLE : H_END;
            if (hsync_reg) begin
              ack_tgl_reg <= !ack_tgl_reg;
            end else begin
              async_ready <= 1'b1;
            end
            if (!hreq_reg.hit && !hreq_reg.write) begin
              host_data_out <= WORD_RESET;
              host_data_oe  <= 1'b1;
            end
          end else if (!hreq_reg.write && wb_empty) begin
            // Reads wait for older writes so they see their own data
            rd_pend_reg <= 1'b1;
            hstate_reg  <= H_RDWAIT;
          end
        end
        H_RDWAIT: begin
          if (hrd_done) begin
            rd_pend_reg   <= 1'b0;
            host_data_out <= lane_steer(rdata_next, hreq_reg.a1,
                                        host_bus16);
            host_data_oe  <= 1'b1;
            hstate_reg    <= hsync_reg ? H_IDLE : H_END;
            if (hsync_reg) begin
              ack_tgl_reg <= !ack_tgl_reg;
            end else begin
              async_ready <= 1'b1;
            end
          end
        end
        H_END: begin
          if (rd_s2 && wr_s2) begin
            host_data_oe <= 1'b0;
            hstate_reg   <= H_IDLE;
          end
        end
        default: hstate_reg <= H_IDLE;
      endcase
    end
  end

  // Sequential data pointer; advances after the top byte lane is used
  logic ptr_step;
  assign ptr_step = wb_push ||
                    ((hstate_reg == H_EXEC) && !hreq_reg.write &&
                     hreq_reg.hit && wb_empty);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_reg <= PTR_RESET;
    end else if (ptr_load) begin
      ptr_reg <= ptr_value;
    end else if (ptr_step && !hreq_reg.be_n[BE_W-1]) begin
      ptr_reg <= ptr_reg + RAM_AW'(1);
    end
  end

  logic [RAM_AW-1:0] hrd_addr_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrd_addr_reg <= PTR_RESET;
    end else if (ptr_step && !hreq_reg.write) begin
      hrd_addr_reg <= ptr_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (wb_push) begin
      wb_mem[wb_wptr_reg].addr <= ptr_reg;
      wb_mem[wb_wptr_reg].data <= lane_steer(hreq_reg.data, hreq_reg.a1,
                                             host_bus16);
      wb_mem[wb_wptr_reg].be   <= ~hreq_reg.be_n;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_wptr_reg  <= '0;
      wb_rptr_reg  <= '0;
      wb_count_reg <= '0;
    end else begin
      if (wb_push) begin
        wb_wptr_reg <= (wb_wptr_reg == WP_W'(WBUF_DEPTH - 1)) ? '0 :
                       wb_wptr_reg + WP_W'(1);
      end
      if (wb_pop) begin
        wb_rptr_reg <= (wb_rptr_reg == WP_W'(WBUF_DEPTH - 1)) ? '0 :
                       wb_rptr_reg + WP_W'(1);
      end
      if (wb_push && !wb_pop) begin
        wb_count_reg <= wb_count_reg + WC_W'(1);
      end else if (wb_pop && !wb_push) begin
        wb_count_reg <= wb_count_reg - WC_W'(1);
      end
    end
  end

  pra_mem_e   mstate_reg;
  pra_owner_e owner_reg;
  logic [CNT_W-1:0]  mcnt_reg;
  logic [RAM_AW-1:0] tx_addr_reg, rx_addr_reg;
  logic last_host_reg, last_tx_reg;
  logic fin;
  assign fin        = (mstate_reg == MEM_BUSY) && (mcnt_reg == '0);
  assign rdata_next = ram_data_in;
  assign hrd_done   = fin && (owner_reg == OWN_HRD);
  assign wb_pop     = fin && (owner_reg == OWN_HWR);

  // A finishing owner is masked so it is not granted its old request again
  logic hw_rq, hr_rq, tx_rq, rx_rq, host_rq, dma_rq, pick_host, pick_tx;
  assign hw_rq   = !wb_empty && !wb_pop;
  assign hr_rq   = rd_pend_reg && wb_empty && !hrd_done;
  assign tx_rq   = tx_fetch_req && !tx_word_valid &&
                   !(fin && owner_reg == OWN_TX);
  assign rx_rq   = rx_word_valid && !rx_word_taken &&
                   !(fin && owner_reg == OWN_RX);
  assign host_rq = hw_rq || hr_rq;
  assign dma_rq  = tx_rq || rx_rq;
  assign pick_host = host_rq && (!dma_rq || !last_host_reg);
  assign pick_tx   = tx_rq && (!rx_rq || !last_tx_reg);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mstate_reg               <= MEM_IDLE;
      owner_reg                <= OWN_HWR;
      mcnt_reg                 <= '0;
      last_host_reg            <= 1'b0;
      last_tx_reg              <= 1'b0;
      ram_address_lines        <= PTR_RESET;
      ram_data_lines           <= WORD_RESET;
      ram_data_oe              <= 1'b0;
      ram_output_enable_n      <= 1'b1;
      ram_byte_write_strobes_n <= STRB_IDLE;
    end else if ((mstate_reg == MEM_IDLE || fin) &&
                 (host_rq || dma_rq)) begin
      mstate_reg    <= MEM_BUSY;
      mcnt_reg      <= CNT_W'(MEM_CYC - 1);
      last_host_reg <= pick_host;
      if (pick_host && hw_rq) begin
        owner_reg                <= OWN_HWR;
        ram_address_lines        <= wb_mem[wb_rptr_reg].addr;
        ram_data_lines           <= wb_mem[wb_rptr_reg].data;
        ram_data_oe              <= 1'b1;
        ram_output_enable_n      <= 1'b1;
        ram_byte_write_strobes_n <= ~wb_mem[wb_rptr_reg].be;
      end else if (pick_host) begin
        owner_reg                <= OWN_HRD;
        ram_address_lines        <= hrd_addr_reg;
        ram_data_oe              <= 1'b0;
        ram_output_enable_n      <= 1'b0;
        ram_byte_write_strobes_n <= STRB_IDLE;
      end else if (pick_tx) begin
        owner_reg                <= OWN_TX;
        last_tx_reg              <= 1'b1;
        ram_address_lines        <= tx_addr_reg;
        ram_data_oe              <= 1'b0;
        ram_output_enable_n      <= 1'b0;
        ram_byte_write_strobes_n <= STRB_IDLE;
      end else begin
        owner_reg                <= OWN_RX;
        last_tx_reg              <= 1'b0;
        ram_address_lines        <= rx_addr_reg;
        ram_data_lines           <= rx_word;
        ram_data_oe              <= 1'b1;
        ram_output_enable_n      <= 1'b1;
        ram_byte_write_strobes_n <= '0;
      end
    end else if (fin) begin
      mstate_reg               <= MEM_IDLE;
      ram_data_oe              <= 1'b0;
      ram_output_enable_n      <= 1'b1;
      ram_byte_write_strobes_n <= STRB_IDLE;
    end else if (mstate_reg == MEM_BUSY) begin
      mcnt_reg <= mcnt_reg - CNT_W'(1);
    end
  end

  // Separate transmit and receive word counters
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_addr_reg   <= PTR_RESET;
      tx_word_valid <= 1'b0;
      tx_word       <= WORD_RESET;
    end else begin
      if (tx_addr_load) begin
        tx_addr_reg <= tx_addr_value;
      end else if (fin && owner_reg == OWN_TX) begin
        tx_addr_reg <= tx_addr_reg + RAM_AW'(1);
      end
      if (fin && owner_reg == OWN_TX) begin
        tx_word_valid <= 1'b1;
        tx_word       <= ram_data_in;
      end else if (tx_word_ready) begin
        tx_word_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_addr_reg   <= PTR_RESET;
      rx_word_taken <= 1'b0;
    end else begin
      rx_word_taken <= fin && owner_reg == OWN_RX;
      if (rx_addr_load) begin
        rx_addr_reg <= rx_addr_value;
      end else if (fin && owner_reg == OWN_RX) begin
        rx_addr_reg <= rx_addr_reg + RAM_AW'(1);
      end
    end
  end
endmodule

// File: pra_pkg.sv
// Purpose: Shared constants and types of the packet RAM arbiter.
// Assumes: 25 MHz crystal doubled to the 50 MHz core clock.
// Notes:   Timing counts derive from the nanosecond figures below.
package pra_pkg;
  localparam int XTAL_MHZ          = 25;
  localparam int CLK_MHZ           = 2 * XTAL_MHZ;
  localparam int CLK_PERIOD_PS     = 1000000 / CLK_MHZ;
  localparam int SRAM_ACCESS_NS    = 25;
  // Least time: round up to whole cycles
  localparam int RAM_ACC_CYC       =
    (SRAM_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOST_DW_PERIOD_NS = 80;
  // Half the host doubleword period, so a MAC cycle fits in between
  localparam int HOST_SLOT_CYC     =
    (HOST_DW_PERIOD_NS * 1000 / CLK_PERIOD_PS) / 2;
  localparam int MEM_CYC           =
    (RAM_ACC_CYC > HOST_SLOT_CYC) ? RAM_ACC_CYC : HOST_SLOT_CYC;
  localparam int CNT_W             = $clog2(MEM_CYC + 1);
  localparam int DATA_W            = 32;
  localparam int BE_W              = 4;
  localparam int RAM_AW            = 15;
  localparam int HADDR_W           = 15;
  localparam logic [RAM_AW-1:0] PTR_RESET  = 15'h0000;
  localparam logic [BE_W-1:0]   STRB_IDLE  = 4'hf;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam int WBUF_DEPTH_DEF    = 2;

  typedef struct packed {
    logic              write;
    logic              hit;
    logic              a1;
    logic [BE_W-1:0]   be_n;
    logic [DATA_W-1:0] data;
  } pra_hreq_s;

  typedef struct packed {
    logic [RAM_AW-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0]   be;
  } pra_wentry_s;

  typedef enum logic [1:0] {OWN_HWR, OWN_HRD, OWN_TX, OWN_RX} pra_owner_e;
  typedef enum logic {MEM_IDLE, MEM_BUSY} pra_mem_e;
  typedef enum logic [1:0] {H_IDLE, H_EXEC, H_RDWAIT, H_END} pra_host_e;
  typedef enum logic {L_IDLE, L_WAIT} pra_lbus_e;
endpackage

// File: pra_sram_model.sv
// Purpose: Behavioural model of the four byte-wide packet SRAMs.
// Assumes: Word addressed; only the low eight address bits decode.
// Notes:   A released bus shows the inverse of the last word read.
`timescale 1ns/1ps
module pra_sram_model (
  input  wire logic                        clk,
  input  wire logic [pra_pkg::RAM_AW-1:0]  ram_address_lines,
  input  wire logic [pra_pkg::DATA_W-1:0]  ram_data_lines,
  input  wire logic                        ram_output_enable_n,
  input  wire logic [pra_pkg::BE_W-1:0]    ram_byte_write_strobes_n,
  output logic [pra_pkg::DATA_W-1:0]       ram_data_in
);
  import pra_pkg::*;
  logic [DATA_W-1:0] mem [0:255];
  logic [DATA_W-1:0] last_reg = WORD_RESET;
  logic [7:0]        wa;
  assign wa = ram_address_lines[7:0];
  // Each strobe is its own chip, so lanes are written one by one
  always @(posedge clk) begin
    for (int b = 0; b < BE_W; b++) begin
      if (!ram_byte_write_strobes_n[b])
        mem[wa][8*b +: 8] <= ram_data_lines[8*b +: 8];
    end
    if (!ram_output_enable_n)
      last_reg <= mem[wa];
  end
  // No held copy on a released bus: a stale sample must not match
  assign ram_data_in = ram_output_enable_n ? ~last_reg : mem[wa];
endmodule

// File: pra_packet_ram_arbiter_checker.sv
// Purpose: Port-level assertions for the packet RAM arbiter.
// Assumes: MEM_CYC of two cycles, one host cycle outstanding.
// Notes:   Attached to every arbiter instance by the bind below.
`timescale 1ns/1ps
module pra_packet_ram_arbiter_checker (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       local_bus_clock,
  input wire logic                       sync_ready_n,
  input wire logic                       host_write_strobe_n,
  input wire logic                       host_read_strobe_n,
  input wire logic                       async_ready,
  input wire logic                       tx_word_valid,
  input wire logic [pra_pkg::DATA_W-1:0] tx_word,
  input wire logic                       tx_word_ready,
  input wire logic                       rx_word_taken,
  input wire logic [pra_pkg::RAM_AW-1:0] ram_address_lines,
  input wire logic                       ram_data_oe,
  input wire logic                       ram_output_enable_n,
  input wire logic [pra_pkg::BE_W-1:0]   ram_byte_write_strobes_n
);
  import pra_pkg::*;
  a_strobe_hold: assert property (@(posedge clk) disable iff (reset)
    $fell(&ram_byte_write_strobes_n) |=> $stable(ram_byte_write_strobes_n)
    && $stable(ram_address_lines)) else $error("write cycle too short");
  a_read_hold: assert property (@(posedge clk) disable iff (reset)
    $fell(ram_output_enable_n) |=> !ram_output_enable_n
    && $stable(ram_address_lines)) else $error("read cycle too short");
  a_one_owner: assert property (@(posedge clk) disable iff (reset)
    !(!ram_output_enable_n && ram_byte_write_strobes_n != 4'hf))
    else $error("read and write together");
  a_write_drives: assert property (@(posedge clk) disable iff (reset)
    ram_byte_write_strobes_n != 4'hf |-> ram_data_oe)
    else $error("write without data drive");
  a_rx_pulse: assert property (@(posedge clk) disable iff (reset)
    rx_word_taken |=> !rx_word_taken) else $error("rx taken too long");
  a_tx_hold: assert property (@(posedge clk) disable iff (reset)
    tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word))
    else $error("tx word lost on stall");
  a_ready_lead: assert property (@(posedge clk) disable iff (reset)
    $fell(host_write_strobe_n) && host_read_strobe_n && async_ready
    |-> ##[1:5] !async_ready) else $error("ready not dropped");
  a_ready_trail: assert property (@(posedge clk) disable iff (reset)
    $fell(async_ready) |-> ##[1:60] async_ready)
    else $error("ready held too long");
  a_srdy_pulse: assert property (@(posedge local_bus_clock)
    disable iff (reset) !sync_ready_n |=> sync_ready_n)
    else $error("sync ready too long");
  c_rx: cover property (@(posedge clk) rx_word_taken);
  c_tx: cover property (@(posedge clk) tx_word_valid && tx_word_ready);
  c_sync: cover property (@(posedge local_bus_clock) !sync_ready_n);
endmodule
bind pra_packet_ram_arbiter pra_packet_ram_arbiter_checker chk_i (.clk,
  .reset, .local_bus_clock, .sync_ready_n, .host_write_strobe_n,
  .host_read_strobe_n, .async_ready, .tx_word_valid, .tx_word,
  .tx_word_ready, .rx_word_taken, .ram_address_lines, .ram_data_oe,
  .ram_output_enable_n, .ram_byte_write_strobes_n);

// File: tb_packet_ram_arbiter.sv
// Purpose: Self-checking bench for the packet RAM arbiter.
// Assumes: Inputs change on falling edges of their own clock.
// Notes:   Expected words come from values preloaded in the SRAM model or driven by the bench.
`timescale 1ns/1ps
module tb_packet_ram_arbiter;
  import pra_pkg::*;
  logic clk = 1'b0, reset = 1'b1, local_bus_clock = 1'b0;
  logic local_bus_mode_n = 1'b1, cycle_start_n = 1'b1, host_bus16 = 1'b0;
  logic address_strobe_n = 1'b1, host_write_not_read = 1'b0;
  logic host_read_strobe_n = 1'b1, host_write_strobe_n = 1'b1;
  logic data_port_select_n = 1'b1, data_reg_select = 1'b0;
  logic ptr_load = 1'b0, tx_addr_load = 1'b0, rx_addr_load = 1'b0;
  logic tx_fetch_req = 1'b0, tx_word_ready = 1'b0, rx_word_valid = 1'b0;
  logic sync_ready_n, host_data_oe, async_ready, tx_word_valid;
  logic rx_word_taken, ram_data_oe, ram_output_enable_n;
  logic [HADDR_W-1:0] host_address = 15'h0000;
  logic [BE_W-1:0]    host_byte_enable_n = 4'h0, ram_byte_write_strobes_n;
  logic [RAM_AW-1:0]  ptr_value = 15'h0000, tx_addr_value = 15'h0000;
  logic [RAM_AW-1:0]  rx_addr_value = 15'h0000, ram_address_lines;
  logic [DATA_W-1:0]  host_data_in = 32'h0, rx_word = 32'h0;
  logic [DATA_W-1:0]  host_data_out, tx_word, ram_data_in, ram_data_lines;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  pra_packet_ram_arbiter uut (.clk, .reset, .local_bus_clock,
    .local_bus_mode_n, .cycle_start_n, .sync_ready_n, .address_strobe_n,
    .host_address, .host_byte_enable_n, .host_write_not_read,
    .host_read_strobe_n, .host_write_strobe_n, .data_port_select_n,
    .data_reg_select, .host_bus16, .host_data_in, .host_data_out,
    .host_data_oe, .async_ready, .ptr_load, .ptr_value, .tx_addr_load,
    .tx_addr_value, .tx_fetch_req, .tx_word_valid, .tx_word, .tx_word_ready,
    .rx_addr_load, .rx_addr_value, .rx_word_valid, .rx_word, .rx_word_taken,
    .ram_address_lines, .ram_data_in, .ram_data_lines, .ram_data_oe,
    .ram_output_enable_n, .ram_byte_write_strobes_n);
  pra_sram_model ram (.clk, .ram_address_lines, .ram_data_lines,
    .ram_output_enable_n, .ram_byte_write_strobes_n, .ram_data_in);
  always #10 clk = ~clk;
  always #32 local_bus_clock = ~local_bus_clock;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic tx_take(input logic [31:0] exp);
    for (int i = 0; i < 40 && tx_word_valid !== 1'b1; i++) @(negedge clk);
    chk(tx_word, exp, "tx word");
    tx_word_ready = 1'b1;
    @(negedge clk);
    tx_word_ready = 1'b0;
  endtask
  // Receive store and transmit fetch compete, with the MAC stalling
  task automatic t_dma();
    ram.mem[8'h20] = 32'h0bad_f00d;
    ram.mem[8'h21] = 32'h1357_9bdf;
    rx_addr_value = 15'h0010;
    tx_addr_value = 15'h0020;
    rx_addr_load = 1'b1;
    tx_addr_load = 1'b1;
    @(negedge clk);
    rx_addr_load = 1'b0;
    tx_addr_load = 1'b0;
    rx_word = 32'hdead_beef;
    rx_word_valid = 1'b1;
    tx_fetch_req = 1'b1;
    for (int i = 0; i < 40 && rx_word_taken !== 1'b1; i++) @(negedge clk);
    rx_word_valid = 1'b0;
    repeat (6) @(negedge clk);
    tx_take(32'h0bad_f00d);
    tx_take(32'h1357_9bdf);
    tx_fetch_req = 1'b0;
    chk(ram.mem[8'h10], 32'hdead_beef, "rx store");
    $display("test dma done");
  endtask
  task automatic host_cyc(input logic wr, input logic [3:0] be_n,
                          input logic [31:0] d, exp);
    host_byte_enable_n = be_n;
    host_data_in = d;
    address_strobe_n = 1'b0;
    @(negedge clk);
    address_strobe_n = 1'b1;
    if (wr)
      host_write_strobe_n = 1'b0;
    else
      host_read_strobe_n = 1'b0;
    for (int i = 0; i < 20 && async_ready !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 80 && async_ready !== 1'b1; i++) @(negedge clk);
    if (!wr)
      chk(host_data_out, exp, "async read");
    host_write_strobe_n = 1'b1;
    host_read_strobe_n = 1'b1;
    repeat (5) @(negedge clk);
    chk({31'h0, host_data_oe}, 32'h0, "data drive kept");
  endtask
  task automatic load_ptr(input logic [14:0] p);
    ptr_value = p;
    ptr_load = 1'b1;
    @(negedge clk);
    ptr_load = 1'b0;
  endtask
  // A byte write that has drained to the SRAM before a read of the same word follows
  task automatic t_async();
    ram.mem[8'h05] = 32'h1122_3344;
    load_ptr(15'h0005);
    data_reg_select = 1'b1;
    host_cyc(1'b1, 4'he, 32'h0000_00aa, 32'h0);
    load_ptr(15'h0005);
    data_reg_select = 1'b0;
    data_port_select_n = 1'b0;
    host_cyc(1'b0, 4'h0, 32'h0, 32'h1122_33aa);
    data_port_select_n = 1'b1;
    chk(ram.mem[8'h05], 32'h1122_33aa, "byte lanes");
    $display("test async done");
  endtask
  task automatic t_sync();
    ram.mem[8'h07] = 32'hcafe_0001;
    load_ptr(15'h0007);
    local_bus_mode_n = 1'b0;
    data_port_select_n = 1'b0;
    host_bus16 = 1'b1;
    host_address = 15'h0001;
    address_strobe_n = 1'b0;
    repeat (3) @(negedge local_bus_clock);
    cycle_start_n = 1'b0;
    @(negedge local_bus_clock);
    cycle_start_n = 1'b1;
    address_strobe_n = 1'b1;
    for (int i = 0; i < 40 && sync_ready_n !== 1'b0; i++)
      @(negedge local_bus_clock);
    chk(host_data_out, 32'h0001_cafe, "sync read");
    @(negedge local_bus_clock);
    chk({31'h0, sync_ready_n}, 32'h1, "sync ready width");
    local_bus_mode_n = 1'b1;
    data_port_select_n = 1'b1;
    $display("test sync done");
  endtask
  initial begin
    repeat (2) @(posedge local_bus_clock);
    @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    t_dma();
    t_async();
    t_sync();
    print_verdict();
  end
endmodule
